// ==== rtl/acsq_pkg.sv ====
/*
 * Package for the converter scan sequencer: register indices, field positions,
 * reset values, timing tables and the state and carrier types.
 * Assumes a 100 MHz system clock that also serves as the converter's oscillator clock.
 */
package acsq_pkg;

    // =========================================================================
    // Register indices (byte address is four times the index)
    // =========================================================================
    localparam logic [11:0] ACSQ_IDX_CONTROL  = 12'h43e;
    localparam logic [11:0] ACSQ_IDX_CHSEL    = 12'h43f;
    localparam logic [11:0] ACSQ_IDX_TIMING   = 12'h4b9;
    localparam logic [11:0] ACSQ_IDX_RES_HI0  = 12'h4c0;
    localparam logic [11:0] ACSQ_IDX_RES_LO   = 12'h4c8;
    localparam logic [11:0] ACSQ_IDX_IRQ_EN   = 12'h4d0;
    localparam logic [11:0] ACSQ_IDX_IRQ_PRIO = 12'h4d1;

    // =========================================================================
    // Field positions and reset values
    // =========================================================================
    localparam int          ACSQ_BIT_TEN      = 3;
    localparam int          ACSQ_BIT_CONT     = 2;
    localparam int          ACSQ_BIT_START    = 1;
    localparam int          ACSQ_BIT_DONE     = 0;
    localparam int          ACSQ_BIT_ADC_EN   = 0;
    localparam int          ACSQ_BIT_GLOB_EN  = 1;
    localparam logic [7:0]  ACSQ_RST_BYTE     = 8'h00;
    localparam logic [3:0]  ACSQ_RST_NIBBLE   = 4'h0;

    // =========================================================================
    // Timing tables in oscillator clocks, indexed by the timing configuration
    // =========================================================================
    localparam logic [15:0][7:0] ACSQ_CONV8 = {
        8'd176, 8'd172, 8'd152, 8'd136, 8'd146, 8'd132, 8'd128, 8'd124,
        8'd108, 8'd116, 8'd104, 8'd100, 8'd96,  8'd80,  8'd76,  8'd72};
    localparam logic [15:0][7:0] ACSQ_CONV10 = {
        8'd208, 8'd204, 8'd180, 8'd160, 8'd170, 8'd156, 8'd152, 8'd148,
        8'd128, 8'd136, 8'd124, 8'd120, 8'd116, 8'd96,  8'd92,  8'd88};
    localparam logic [15:0][7:0] ACSQ_SAMP_TBL = {
        8'd24,  8'd22,  8'd20,  8'd20,  8'd32,  8'd18,  8'd16,  8'd14,
        8'd14,  8'd24,  8'd12,  8'd10,  8'd8,   8'd8,   8'd6,   8'd4};

    // =========================================================================
    // Types
    // =========================================================================
    typedef enum logic [2:0] {
        ACSQ_IDLE    = 3'b001,
        ACSQ_SAMPLE  = 3'b010,
        ACSQ_CONVERT = 3'b100
    } acsq_fsm_t;

    typedef struct packed {
        logic [2:0] channel;
        logic       sample;
        logic       convert;
        logic       ten_bit;
    } acsq_core_req_t;

    typedef struct packed {
        acsq_fsm_t       fsm;
        logic            ten;
        logic            cont;
        logic            busy;
        logic            done;
        logic [7:0]      chsel;
        logic [3:0]      timing;
        logic            irq_adc_en;
        logic            irq_glob_en;
        logic [3:0]      irq_prio;
        logic [7:0]      cnt;
        logic [7:0][7:0] res_hi;
        logic [7:0]      res_lo;
        logic            waitreq;
        logic [31:0]     rdata;
        logic            irq;
        acsq_core_req_t  core;
    } acsq_state_t;

endpackage

// ==== rtl/acsq_scan_sequencer.sv ====
/*
 * Scan sequencer for an eight-channel converter: register file on an Avalon-MM
 * slave with waitrequest, channel scan state machine, result capture and the
 * converter interrupt request.
 * Assumes the analog core sits on sys_clk and presents its result on conv_result
 * while convert is high; running_priority comes from the processor on sys_clk.
 */
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps

// Functional notes
// - Eight channels, one result register per channel, 8-bit results by default.
// - Resolution bit 0 selects 8-bit, 1 selects 10-bit conversions.
// - 10-bit conversions run longer; software picks a suitable timing value.
// - Mode bit 1 scans continuously, 0 scans once after a start.
// - Only channels with their select bit set are converted; others skipped.
// - Each result lands in the high result register of its channel.
// - In 10-bit mode the two low bits sit at the top of the low register.
// - Writing 1 to the start bit begins a scan of the selected channels.
// - Start bit stays 1 while converting; cleared when a single scan ends.
// - Single scan converts each selected channel once, then sets the done flag.
// - Continuous scan cycles through selected channels until software stops it.
// - Continuous scan sets the done flag after each full pass.
// - Writing 1 to the start bit while busy is ignored.
// - Writing 0 to the start bit aborts the scan in progress.
// - Hardware never clears the done flag; only a software 0 does.
// - Interrupt request when flag, both enables set and priority beats running.
// - Timing values 6 and B sample longer than either of their neighbours.
// - Four-bit timing field selects sampling and conversion length in clocks.
// - A done flag set in the same cycle as a software clear is not lost.
module acsq_scan_sequencer
    import acsq_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Avalon-MM slave, word addressed
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Analog core
    output acsq_core_req_t         core_req,
    input  wire logic [9:0]        conv_result,
    // Interrupt
    input  wire logic [3:0]        running_priority,
    output logic                   adc_irq_req
);

    // =========================================================================
    // Helpers
    // =========================================================================
    // Returns {found, channel}: lowest selected channel above 'from', or at it
    // when 'incl' is set.
    function automatic logic [3:0] acsq_find(input logic [7:0] sel, input logic [2:0] from,
                                             input logic incl);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (sel[i] && ((3'(i) > from) || (incl && (3'(i) == from)))) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

    acsq_state_t s_r;
    acsq_state_t s_nxt;

    // =========================================================================
    // Next state
    // =========================================================================
    always_comb begin
        logic       acc;
        logic       wr;
        logic [3:0] hit;
        logic [7:0] samp;
        logic [7:0] conv;
        logic [7:0] wbyte;
        acc   = (avs_read || avs_write) && s_r.waitreq;
        wr    = avs_write && !s_r.waitreq && avs_byteenable[0];
        wbyte = avs_writedata[7:0];
        hit   = 4'h0;
        s_nxt = s_r;
        samp = ACSQ_SAMP_TBL[s_r.timing];
        conv = s_r.ten ? ACSQ_CONV10[s_r.timing] : ACSQ_CONV8[s_r.timing];

        // Bus handshake: one wait cycle, then a single low cycle per request.
        s_nxt.waitreq = !acc;
        if (acc) begin
            s_nxt.rdata = 32'h0;
            if (avs_address == ADDR_W'(ACSQ_IDX_CONTROL)) begin
                s_nxt.rdata[7:0] = {4'h0, s_r.ten, s_r.cont, s_r.busy, s_r.done};
            end else if (avs_address == ADDR_W'(ACSQ_IDX_CHSEL)) begin
                s_nxt.rdata[7:0] = s_r.chsel;
            end else if (avs_address == ADDR_W'(ACSQ_IDX_TIMING)) begin
                s_nxt.rdata[7:0] = {4'h0, s_r.timing};
            end else if (avs_address == ADDR_W'(ACSQ_IDX_RES_LO)) begin
                s_nxt.rdata[7:0] = s_r.res_lo;
            end else if (avs_address == ADDR_W'(ACSQ_IDX_IRQ_EN)) begin
                s_nxt.rdata[7:0] = {6'h0, s_r.irq_glob_en, s_r.irq_adc_en};
            end else if (avs_address == ADDR_W'(ACSQ_IDX_IRQ_PRIO)) begin
                s_nxt.rdata[7:0] = {4'h0, s_r.irq_prio};
            end else if (avs_address[ADDR_W-1:3] == ACSQ_IDX_RES_HI0[ADDR_W-1:3]) begin
                s_nxt.rdata[7:0] = s_r.res_hi[avs_address[2:0]];
            end
        end

        // Register writes; reserved bits are not stored and read as zero.
        if (wr) begin
            if (avs_address == ADDR_W'(ACSQ_IDX_CONTROL)) begin
                s_nxt.ten  = wbyte[ACSQ_BIT_TEN];
                s_nxt.cont = wbyte[ACSQ_BIT_CONT];
                if (!wbyte[ACSQ_BIT_DONE]) begin
                    s_nxt.done = 1'b0;
                end
                if (wbyte[ACSQ_BIT_START] && !s_r.busy) begin
                    hit = acsq_find(s_r.chsel, 3'd0, 1'b1);
                    if (hit[3]) begin
                        s_nxt.busy         = 1'b1;
                        s_nxt.fsm          = ACSQ_SAMPLE;
                        s_nxt.core.channel = hit[2:0];
                        s_nxt.cnt          = ACSQ_SAMP_TBL[s_r.timing] - 8'd1;
                    end else begin
                        s_nxt.done = 1'b1;
                    end
                end else if (!wbyte[ACSQ_BIT_START] && s_r.busy) begin
                    s_nxt.busy = 1'b0;
                    s_nxt.fsm  = ACSQ_IDLE;
                end
                // start while busy falls through unchanged.
            end else if (avs_address == ADDR_W'(ACSQ_IDX_CHSEL)) begin
                s_nxt.chsel = wbyte;
            end else if (avs_address == ADDR_W'(ACSQ_IDX_TIMING)) begin
                s_nxt.timing = wbyte[3:0];
            end else if (avs_address == ADDR_W'(ACSQ_IDX_IRQ_EN)) begin
                s_nxt.irq_adc_en  = wbyte[ACSQ_BIT_ADC_EN];
                s_nxt.irq_glob_en = wbyte[ACSQ_BIT_GLOB_EN];
            end else if (avs_address == ADDR_W'(ACSQ_IDX_IRQ_PRIO)) begin
                s_nxt.irq_prio = wbyte[3:0];
            end
        end

        // Scan engine. An abort written this cycle overrides the engine.
        if (!(wr && (avs_address == ADDR_W'(ACSQ_IDX_CONTROL)) && s_nxt.fsm == ACSQ_IDLE)) begin
            case (s_r.fsm)
                ACSQ_IDLE: begin
                end
                ACSQ_SAMPLE: begin
                    if (s_r.cnt == 8'd0) begin
                        s_nxt.fsm = ACSQ_CONVERT;
                        s_nxt.cnt = conv - samp - 8'd1;
                    end else begin
                        s_nxt.cnt = s_r.cnt - 8'd1;
                    end
                end
                ACSQ_CONVERT: begin
                    if (s_r.cnt != 8'd0) begin
                        s_nxt.cnt = s_r.cnt - 8'd1;
                    end else begin
                        // result capture; low bits are overwritten by each 10-bit capture.
                        if (s_r.ten) begin
                            s_nxt.res_hi[s_r.core.channel] = conv_result[9:2];
                            s_nxt.res_lo                   = {conv_result[1:0], 6'h00};
                        end else begin
                            s_nxt.res_hi[s_r.core.channel] = conv_result[7:0];
                        end
                        hit = acsq_find(s_r.chsel, s_r.core.channel, 1'b0);
                        if (!hit[3]) begin
                            // pass done; the set wins over a clear
                            s_nxt.done = 1'b1;
                            if (s_r.cont) begin
                                hit = acsq_find(s_r.chsel, 3'd0, 1'b1);
                            end
                        end
                        if (hit[3]) begin
                            s_nxt.fsm          = ACSQ_SAMPLE;
                            s_nxt.core.channel = hit[2:0];
                            s_nxt.cnt          = samp - 8'd1;
                        end else begin
                            s_nxt.fsm  = ACSQ_IDLE;
                            s_nxt.busy = 1'b0;
                        end
                    end
                end
                default: begin
                    s_nxt.fsm  = ACSQ_IDLE;
                    s_nxt.busy = 1'b0;
                end
            endcase
        end

        s_nxt.core.sample  = (s_nxt.fsm == ACSQ_SAMPLE);
        s_nxt.core.convert = (s_nxt.fsm == ACSQ_CONVERT);
        s_nxt.core.ten_bit = s_nxt.ten;
        s_nxt.irq = s_nxt.done && s_nxt.irq_adc_en && s_nxt.irq_glob_en && (s_nxt.irq_prio > running_priority);
    end

    // =========================================================================
    // State register
    // =========================================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r             <= '0;
            s_r.fsm         <= ACSQ_IDLE;
            s_r.chsel       <= ACSQ_RST_BYTE;
            s_r.timing      <= ACSQ_RST_NIBBLE;
            s_r.waitreq     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata    = s_r.rdata;
    assign avs_waitrequest = s_r.waitreq;
    assign core_req        = s_r.core;
    assign adc_irq_req     = s_r.irq;

endmodule // acsq_scan_sequencer

// ==== verif/acsq_core_model.sv ====
/*
 * Stand-in for the analog converter core: drives a channel-dependent result.
 * Assumes the sequencer captures conv_result in its last convert cycle.
 */
`timescale 1ns/1ps
module acsq_core_model
    import acsq_pkg::*;
(
    // Clock and request
    input  wire logic           sys_clk,
    input  wire acsq_core_req_t core_req,
    // Result seed and result
    input  wire logic [9:0]     base,
    output logic      [9:0]     conv_result
);
    // =========================================================================
    // Result path
    // =========================================================================
    initial conv_result = 10'h155;
    always @(posedge sys_clk) begin
        // Outside a conversion the bits toggle, so a capture at the wrong time is seen.
        conv_result <= core_req.convert ? base + 10'(core_req.channel) * 10'h51 : ~conv_result;
    end
endmodule // acsq_core_model

// ==== verif/acsq_scan_sequencer_assertions.sv ====
/*
 * Port checks for the scan sequencer, bound to every instance.
 * Assumes one clock domain and reset held for at least one edge.
 */
`timescale 1ns/1ps
module acsq_scan_sequencer_assertions
    import acsq_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rst,
    // Register bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    // Core and interrupt
    input wire acsq_core_req_t    core_req,
    input wire logic [9:0]        conv_result,
    input wire logic [3:0]        running_priority,
    input wire logic              adc_irq_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // =========================================================================
    // Register bus, scan engine and interrupt
    // =========================================================================
    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one cycle");
    chk_wait_idle: assert property (!$past(avs_read || avs_write) |-> avs_waitrequest)
        else $error("waitrequest low without a request");
    chk_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data changed outside an answer");
    chk_phase_excl: assert property (!(core_req.sample && core_req.convert))
        else $error("sample and convert high together");
    chk_chan_stable: assert property (core_req.convert |-> $stable(core_req.channel))
        else $error("channel changed during conversion");
    // An abort written in the last sampling cycle legally ends sampling without a conversion.
    chk_sample_conv: assert property ($fell(core_req.sample) && !$past(avs_write && !avs_waitrequest) |-> core_req.convert)
        else $error("sampling not followed by conversion");
    chk_abort_stop: assert property (avs_write && !avs_waitrequest && avs_address == ACSQ_IDX_CONTROL &&
        avs_byteenable[0] && !avs_writedata[ACSQ_BIT_START] |=> ##1 !(core_req.sample || core_req.convert))
        else $error("core still active after stop");
    chk_irq_ceiling: assert property ($past(running_priority) == 4'hf |-> !adc_irq_req)
        else $error("request raised against top running priority");
    chk_irq_hold: assert property ($fell(adc_irq_req) |-> $past(avs_write) || $past(avs_write, 2) ||
        $past(avs_write, 3) || !$stable(running_priority) || $past(running_priority) != $past(running_priority, 2))
        else $error("request dropped with no software cause");
    cover property (core_req.convert && core_req.ten_bit);
    cover property ($fell(core_req.convert) && core_req.sample);
    cover property ($rose(adc_irq_req));
endmodule // acsq_scan_sequencer_assertions

bind acsq_scan_sequencer acsq_scan_sequencer_assertions #(.ADDR_W(ADDR_W)) u_chk (.sys_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .core_req,
    .conv_result, .running_priority, .adc_irq_req);

// ==== verif/acsq_scan_sequencer_tb_top.sv ====
/*
 * Self-checking bench: registers, single and continuous scans, abort, interrupt.
 * Assumes the core model stands on the core side of the sequencer.
 */
`timescale 1ns/1ps
module acsq_scan_sequencer_tb_top
    import acsq_pkg::*;
;
    logic           sys_clk = 1'b0;
    logic           rst = 1'b1;
    logic [11:0]    avs_address = 12'h0;
    logic           avs_read = 1'b0;
    logic           avs_write = 1'b0;
    logic [31:0]    avs_writedata = 32'h0;
    logic [3:0]     avs_byteenable = 4'hf;
    logic [31:0]    avs_readdata;
    logic           avs_waitrequest;
    acsq_core_req_t core_req;
    logic [9:0]     conv_result;
    logic [9:0]     base = 10'h0;
    logic [3:0]     running_priority = 4'h0;
    logic           adc_irq_req;
    logic [8:0]     exp_q[$];
    logic [8:0]     mon_e;
    logic [7:0]     exp_hi[8] = '{default: 8'h00};
    logic [7:0]     last_rd;
    logic [3:0]     tim = 4'h0;
    logic           ten = 1'b0;
    logic           len_on = 1'b1;
    logic           was_cv = 1'b0;
    logic           was_sp = 1'b0;
    int             samp_len = 0;
    logic [11:0]    regs[7] = '{ACSQ_IDX_CONTROL, ACSQ_IDX_CHSEL, ACSQ_IDX_TIMING, ACSQ_IDX_RES_LO,
                                ACSQ_IDX_IRQ_EN, ACSQ_IDX_IRQ_PRIO, 12'h000};
    int             num_errors = 0;
    int             checks_done = 0;
    int             run_len = 0;

    always #5 sys_clk = ~sys_clk;

    acsq_scan_sequencer #(.ADDR_W(12)) u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .core_req(core_req), .conv_result(conv_result), .running_priority(running_priority),
        .adc_irq_req(adc_irq_req));
    acsq_core_model u_core (.sys_clk(sys_clk), .core_req(core_req), .base(base), .conv_result(conv_result));

    // =========================================================================
    // Checking and bus tasks
    // =========================================================================
    task chk(input logic [9:0] seen, input logic [9:0] want);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // A read with e[8] set is compared by the monitor; polls leave it clear.
    task acc(input logic rd, input logic [11:0] a, input logic [7:0] d, input logic [8:0] e);
        int i;
        if (rd) exp_q.push_back(e);
        @(posedge sys_clk);
        avs_read <= rd;
        avs_write <= !rd;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        last_rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin num_errors++; results(); end
    endtask

    task wait_bit(input int b, input logic v);
        int i;
        for (i = 0; i < 3000; i++) begin
            acc(1'b1, ACSQ_IDX_CONTROL, 8'h0, 9'h0);
            if (last_rd[b] === v) break;
        end
        if (i == 3000) begin num_errors++; results(); end
    endtask

    // =========================================================================
    // Result monitor
    // =========================================================================
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            mon_e = exp_q.pop_front();
            if (mon_e[8]) chk(avs_readdata[9:0], {2'b0, mon_e[7:0]});
        end
        if (core_req.convert === 1'b1) chk({9'h0, core_req.ten_bit}, {9'h0, ten});
        if (was_sp === 1'b1 && core_req.sample === 1'b0) begin
            if (len_on) chk(10'(samp_len), 10'(ACSQ_SAMP_TBL[tim]));
            samp_len = 0;
        end
        if (core_req.sample === 1'b1) samp_len = samp_len + 1;
        was_sp = core_req.sample;
        if (was_cv === 1'b1 && core_req.convert === 1'b0) begin
            if (len_on) chk(10'(run_len), 10'(ten ? ACSQ_CONV10[tim] : ACSQ_CONV8[tim]));
            run_len = 0;
        end
        if (core_req.sample === 1'b1 || core_req.convert === 1'b1) run_len = run_len + 1;
        was_cv = core_req.convert;
    end

    // =========================================================================
    // Main sequence
    // =========================================================================
    initial begin
        logic [7:0] sel;
        logic [7:0] lo;
        logic [9:0] v;
        int t;
        int n;
        void'($urandom(32'hfc34042d));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (n = 0; n < 15; n++) acc(1'b1, n < 8 ? ACSQ_IDX_RES_HI0 + 12'(n) : regs[n-8], 8'h0, 9'h100);
        avs_byteenable <= 4'h0;
        acc(1'b0, ACSQ_IDX_CHSEL, 8'h5a, 9'h0);
        avs_byteenable <= 4'hf;
        acc(1'b1, ACSQ_IDX_CHSEL, 8'h0, 9'h100);
        acc(1'b0, ACSQ_IDX_RES_HI0, 8'hff, 9'h0);
        acc(1'b1, ACSQ_IDX_RES_HI0, 8'h0, 9'h100);
        acc(1'b0, ACSQ_IDX_IRQ_EN, 8'h03, 9'h0);
        acc(1'b0, ACSQ_IDX_IRQ_PRIO, 8'h08, 9'h0);
        acc(1'b1, ACSQ_IDX_IRQ_EN, 8'h0, 9'h103);
        $display("test registers done");
        for (t = 0; t < 6; t++) begin
            sel = (t == 0) ? 8'h00 : 8'($urandom);
            tim = 4'($urandom);
            ten = t[0];
            base = 10'($urandom);
            acc(1'b0, ACSQ_IDX_TIMING, {4'h0, tim}, 9'h0);
            acc(1'b0, ACSQ_IDX_CHSEL, sel, 9'h0);
            acc(1'b0, ACSQ_IDX_CONTROL, {4'h0, ten, 3'b010}, 9'h0);
            if (sel != 8'h00) acc(1'b0, ACSQ_IDX_CONTROL, {4'h0, ten, 3'b010}, 9'h0);
            wait_bit(ACSQ_BIT_START, 1'b0);
            acc(1'b1, ACSQ_IDX_CONTROL, 8'h0, {1'b1, 4'h0, ten, 3'b001});
            for (n = 0; n < 8; n++) begin
                v = base + 10'(n) * 10'h51;
                if (sel[n]) exp_hi[n] = ten ? v[9:2] : v[7:0];
                if (sel[n]) lo = {v[1:0], 6'h00};
                acc(1'b1, ACSQ_IDX_RES_HI0 + 12'(n), 8'h0, {1'b1, exp_hi[n]});
            end
            if (ten && sel != 8'h00) acc(1'b1, ACSQ_IDX_RES_LO, 8'h0, {1'b1, lo});
            for (n = 0; n < 2; n++) begin
                running_priority <= 4'($urandom);
                repeat (3) @(posedge sys_clk);
                chk({9'h0, adc_irq_req}, {9'h0, running_priority < 4'h8});
            end
            acc(1'b0, ACSQ_IDX_CONTROL, 8'h00, 9'h0);
            acc(1'b1, ACSQ_IDX_CONTROL, 8'h0, 9'h100);
            $display("test single scan %0d done", t);
        end
        sel = 8'($urandom) | 8'h81;
        tim = 4'h0;
        ten = 1'b0;
        acc(1'b0, ACSQ_IDX_TIMING, 8'h00, 9'h0);
        acc(1'b0, ACSQ_IDX_CHSEL, sel, 9'h0);
        acc(1'b0, ACSQ_IDX_CONTROL, 8'h06, 9'h0);
        wait_bit(ACSQ_BIT_DONE, 1'b1);
        acc(1'b1, ACSQ_IDX_CONTROL, 8'h0, 9'h107);
        for (n = 0; n < 400 && core_req.convert !== 1'b1; n++) @(posedge sys_clk);
        if (n == 400) begin num_errors++; results(); end
        len_on = 1'b0;
        acc(1'b0, ACSQ_IDX_CONTROL, 8'h04, 9'h0);
        repeat (3) @(posedge sys_clk);
        chk({8'h0, core_req.sample, core_req.convert}, 10'h0);
        acc(1'b1, ACSQ_IDX_CONTROL, 8'h0, 9'h104);
        $display("test continuous scan done");
        results();
    end
endmodule // acsq_scan_sequencer_tb_top
